//--- src/fsr_ctrl.v
// status and configuration register bank with its serial read and write commands
`timescale 1ns/1ps
`include "fsr_defines.vh"
module fsr_ctrl #(
    parameter T_W_NS = `FSR_TW_NS
) (
    // clock and reset
    input  wire       clk_sys,
    input  wire       rst_b,
    // serial pins
    input  wire       spi_sck,
    input  wire       spi_cs_b,
    input  wire [3:0] dq_in,
    output reg  [3:0] dq_out,
    output reg  [3:0] dq_oe,
    input  wire       wp_b,
    // command logic mode and latch events
    input  wire       qpi_mode,
    input  wire       wel_set,
    input  wire       wel_clr,
    // array state
    input  wire       array_busy,
    input  wire       erase_active,
    input  wire       program_active,
    // suspend, resume and programming events
    input  wire       suspend_req,
    input  wire       resume_req,
    input  wire       byte_programmed,
    // register contents
    output wire [7:0] status_one,
    output wire [7:0] status_two,
    output wire [7:0] status_three,
    output wire       write_busy_flag,
    output wire       write_enable_latch,
    output wire       hardware_protected_mode,
    output wire [2:0] otp_sector_locked,
    output wire       hold_pin_active,
    output wire       reset_pin_active,
    output wire [1:0] drive_strength,
    output wire [1:0] wrap_burst_len
);

    ////////////////////////////////////////////////////////////////////////////
    // constants
    // write cycle length rounded up to whole system clocks
    localparam [31:0] TW_CYC = (T_W_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS;
    // protect byte reset value, split into status protect and area bits
    localparam [5:0]  PROT_RST = `FSR_PROT_RST;
    // one-hot command states: opcode, read, write, ignore rest of frame
    localparam [3:0] S_OPC = 4'b0001;
    localparam [3:0] S_RD  = 4'b0010;
    localparam [3:0] S_WR  = 4'b0100;
    localparam [3:0] S_IGN = 4'b1000;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    // the link clock is sampled, so it must stay well below a quarter of clk_sys
    // sck and chip select keep a third flop for edge detection
    reg [2:0] sck_s_q;
    reg [2:0] cs_s_q;
    reg [3:0] dq1_q;
    reg [3:0] dq2_q;
    reg [1:0] wp_s_q;

    // two flops before use, third flop only for edges
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sck_s_q <= 3'b000;
            cs_s_q  <= 3'b111;
            dq1_q   <= 4'h0;
            dq2_q   <= 4'h0;
            wp_s_q  <= 2'b11;
        end else begin
            sck_s_q <= {sck_s_q[1:0], spi_sck};
            cs_s_q  <= {cs_s_q[1:0], spi_cs_b};
            dq1_q   <= dq_in;
            dq2_q   <= dq1_q;
            wp_s_q  <= {wp_s_q[0], wp_b};
        end
    end

    // edges come from the second and third flops, levels from the second
    wire sck_rise = sck_s_q[1] & ~sck_s_q[2];
    wire sck_fall = ~sck_s_q[1] & sck_s_q[2];
    wire cs_low   = ~cs_s_q[1];
    wire cs_rise  = cs_s_q[1] & ~cs_s_q[2];
    wire wp_low   = ~wp_s_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // register storage
    // first register: status protect, area bits and latch
    reg       srp_q;
    reg [4:0] prot_q;
    reg       wel_q;

    // second register: suspend flags, complement, locks, quad enable
    reg       esus_q;
    reg       psus_q;
    reg       cmp_q;
    reg [2:0] lock_q;
    reg       qe_q;

    // third register: pin select, drive, wrap, blank
    reg       hrs_q;
    reg [1:0] drv_q;
    reg [1:0] wrp_q;
    reg       blank_q;

    // timed write cycle
    reg       tw_busy_q;
    reg [31:0] tw_cnt_q;

    // wp pin only acts while quad enable is off
    assign hardware_protected_mode = srp_q & wp_low & ~qe_q;
    // busy covers the timed status write and any array operation
    assign write_busy_flag    = tw_busy_q | array_busy;
    assign write_enable_latch = wel_q;
    assign status_one   = {srp_q, prot_q, wel_q, write_busy_flag};
    // bit 0 is reserved and reads zero
    assign status_two   = {esus_q, cmp_q, lock_q, psus_q, qe_q, 1'b0};
    // the two low bits of the third register are reserved and read zero
    assign status_three = {hrs_q, drv_q, wrp_q, blank_q, 2'b00};
    // lock bits sit in the register with sector zero highest
    assign otp_sector_locked = {lock_q[0], lock_q[1], lock_q[2]};
    // pause or reset only while quad enable is zero
    assign hold_pin_active  = ~qe_q & ~hrs_q;
    assign reset_pin_active = ~qe_q & hrs_q;
    // configuration fields straight from their registers
    assign drive_strength = drv_q;
    assign wrap_burst_len = wrp_q;

    ////////////////////////////////////////////////////////////////////////////
    // serial command engine
    reg [3:0] st_q;
    reg [5:0] cnt_q;
    reg [5:0] dcnt_q;
    reg [7:0] sh_q;
    reg [7:0] oreg_q;
    reg [2:0] opos_q;
    reg [7:0] wb0_q;
    reg [7:0] wb1_q;
    reg [7:0] wb2_q;

    // true for either opcode of the third register read
    function fsr_rd3_op;
        input [7:0] op;
        fsr_rd3_op = (op == `FSR_OP_RD3_A) || (op == `FSR_OP_RD3_B);
    endfunction

    // bits per serial clock: one, or four in quad peripheral mode
    wire [5:0] step  = qpi_mode ? 6'h04 : 6'h01;
    wire [7:0] sh_in = qpi_mode ? {sh_q[3:0], dq2_q} : {sh_q[6:0], dq2_q[0]};
    wire [5:0] cnt_n = cnt_q + step;
    // data count saturates so an overlong frame never looks valid
    wire [5:0] dcnt_n = (dcnt_q > 6'h3b) ? 6'h3f : dcnt_q + step;
    // each byte starts from the live third register
    wire [7:0] ow    = (opos_q == 3'd0) ? status_three : oreg_q;

    // a status write needs the latch, no hardware protect and no busy
    wire       wr_ok = wel_q & ~hardware_protected_mode & ~write_busy_flag;
    // frame length judged at chip select rise
    wire       wr_len = (dcnt_q == `FSR_WR_N1) | (dcnt_q == `FSR_WR_N2) |
                        (dcnt_q == `FSR_WR_N4);
    wire       wr_go = (st_q == S_WR) & cs_rise & wr_len;
    // last clock of the timed cycle
    wire       tw_end = tw_busy_q & (tw_cnt_q == TW_CYC - 32'd1);

    // one-hot command states
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q   <= S_OPC;
            cnt_q  <= 6'h00;
            dcnt_q <= 6'h00;
            sh_q   <= 8'h00;
            wb0_q  <= 8'h00;
            wb1_q  <= 8'h00;
            wb2_q  <= 8'h00;
        end else if (!cs_low) begin
            // deselect returns to opcode collection and drops the counts
            st_q   <= S_OPC;
            cnt_q  <= 6'h00;
            dcnt_q <= 6'h00;
        end else if (sck_rise) begin
            // every sampled rising edge shifts data in
            sh_q <= sh_in;
            case (st_q)
                S_OPC: begin
                    cnt_q <= cnt_n;
                    // opcode complete after eight bits; reads are taken at any time
                    if (cnt_n == 6'h08) begin
                        if (fsr_rd3_op(sh_in))
                            st_q <= S_RD;
                        else if (sh_in == `FSR_OP_STATUS_WRITE_CMD && wr_ok)
                            st_q <= S_WR;
                        else
                            st_q <= S_IGN;
                    end
                end
                S_WR: begin
                    dcnt_q <= dcnt_n;
                    // each of the first three full bytes lands in the next register; a fourth byte is dropped
                    if (dcnt_n[2:0] == 3'd0) begin
                        case (dcnt_n[5:3])
                            3'd1:    wb0_q <= sh_in;
                            3'd2:    wb1_q <= sh_in;
                            3'd3:    wb2_q <= sh_in;
                            default: ;
                        endcase
                    end
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data shifter, third register repeats while selected
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dq_out <= 4'h0;
            dq_oe  <= 4'h0;
            oreg_q <= 8'h00;
            opos_q <= 3'd0;
        end else if (!cs_low || st_q != S_RD) begin
            // deselect or any other command releases the lines
            dq_oe  <= 4'h0;
            opos_q <= 3'd0;
        end else if (sck_fall) begin
            // drive out on sampled falling edges
            if (qpi_mode) begin
                dq_out <= ow[7:4];
                dq_oe  <= 4'hf;
            end else begin
                // single mode drives the second data line only
                dq_out <= {2'b00, ow[7], 1'b0};
                dq_oe  <= 4'h2;
            end
            // keep the rest of the byte for the next edges
            oreg_q <= qpi_mode ? {ow[3:0], 4'h0} : {ow[6:0], 1'b0};
            opos_q <= opos_q + step[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // self-timed write cycle and latch
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tw_busy_q <= 1'b0;
            tw_cnt_q  <= 32'd0;
            wel_q     <= 1'b0;
        end else begin
            // start on a valid frame end, count up to the last clock
            if (wr_go) begin
                tw_busy_q <= 1'b1;
                tw_cnt_q  <= 32'd0;
            end else if (tw_end) begin
                tw_busy_q <= 1'b0;
            end else if (tw_busy_q) begin
                tw_cnt_q <= tw_cnt_q + 32'd1;
            end
            // a set arriving with the clear wins
            if (wel_set)
                wel_q <= 1'b1;
            else if (tw_end || wel_clr)
                wel_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register updates from the status write and from the array logic
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            // locks and blank flag have no non-volatile copy in this block
            srp_q   <= PROT_RST[5];
            prot_q  <= PROT_RST[4:0];
            cmp_q   <= `FSR_CMP_RST;
            lock_q  <= 3'b000;
            qe_q    <= `FSR_QE_RST;
            hrs_q   <= `FSR_HRS_RST;
            drv_q   <= `FSR_DRV_RST;
            wrp_q   <= `FSR_WRP_RST;
            blank_q <= `FSR_BLANK_RST;
            esus_q  <= 1'b0;
            psus_q  <= 1'b0;
        end else begin
            if (wr_go) begin
                // busy and latch bits of the data are dropped
                srp_q  <= wb0_q[`FSR_S1_SRP];
                prot_q <= wb0_q[`FSR_S1_BL:`FSR_S1_BP_LO];
                // second register only when at least two bytes came
                if (dcnt_q != `FSR_WR_N1) begin
                    cmp_q  <= wb1_q[`FSR_S2_CMP];
                    // lock bits can only go from zero to one
                    lock_q <= lock_q | wb1_q[`FSR_S2_LK0:`FSR_S2_LK2];
                    qe_q   <= wb1_q[`FSR_S2_QE];
                end
                // third register only with a full four-byte frame
                if (dcnt_q == `FSR_WR_N4) begin
                    hrs_q <= wb2_q[`FSR_S3_HRS];
                    drv_q <= wb2_q[`FSR_S3_DRV_HI:`FSR_S3_DRV_LO];
                    wrp_q <= wb2_q[`FSR_S3_WRP_HI:`FSR_S3_WRP_LO];
                end
            end
            // once programmed the flag stays clear until the next reset
            if (byte_programmed)
                blank_q <= 1'b0;
            // suspend sets over a simultaneous resume
            if (suspend_req && erase_active)
                esus_q <= 1'b1;
            else if (resume_req)
                esus_q <= 1'b0;
            if (suspend_req && program_active)
                psus_q <= 1'b1;
            else if (resume_req)
                psus_q <= 1'b0;
        end
    end

endmodule // fsr_ctrl

//--- src/fsr_defines.vh
// constants for the flash status and configuration register block
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH
// opcodes
`define FSR_OP_STATUS_WRITE_CMD     8'h01
`define FSR_OP_RD3_A    8'h95
`define FSR_OP_RD3_B    8'h15
// first status register fields
`define FSR_S1_SRP      7
`define FSR_S1_BL       6
`define FSR_S1_TB       5
`define FSR_S1_BP_HI    4
`define FSR_S1_BP_LO    2
`define FSR_S1_WEL      1
`define FSR_S1_WIP      0
// second status register fields
`define FSR_S2_ESUS     7
`define FSR_S2_CMP      6
`define FSR_S2_LK0      5
`define FSR_S2_LK1      4
`define FSR_S2_LK2      3
`define FSR_S2_PSUS     2
`define FSR_S2_QE       1
// third status register fields
`define FSR_S3_HRS      7
`define FSR_S3_DRV_HI   6
`define FSR_S3_DRV_LO   5
`define FSR_S3_WRP_HI   4
`define FSR_S3_WRP_LO   3
`define FSR_S3_BLANK    2
// reset values
`define FSR_PROT_RST    6'h00
`define FSR_CMP_RST     1'b0
`define FSR_QE_RST      1'b1
`define FSR_HRS_RST     1'b0
`define FSR_DRV_RST     2'b00
`define FSR_WRP_RST     2'b00
`define FSR_BLANK_RST   1'b1
// data bit counts that end a valid status write
`define FSR_WR_N1       6'h08
`define FSR_WR_N2       6'h10
`define FSR_WR_N4       6'h20
// timing
`define FSR_CLK_NS      50
`define FSR_TW_NS       2000000
`endif

//--- verif/fsr_host_model.sv
// host side model: drives serial frames and collects reply bits
`timescale 1ns/1ps
module fsr_host_model (
    // serial pins towards the block
    output logic       spi_sck,
    output logic       spi_cs_b,
    output logic [3:0] dq_in,
    // reply lines and their enables
    input  wire  [3:0] dq_out,
    input  wire  [3:0] dq_oe
);
    // a line nobody drives shows the inverse of the last value, so a late enable shows up
    wire [3:0] dq_line = dq_out ^ ~dq_oe;
    // idle pins: clock low, chip deselected
    initial begin
        spi_sck  = 1'h0;
        spi_cs_b = 1'h1;
        dq_in    = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // opcode then n data bits msb first, one or four lines per clock
    task automatic frame(input logic [7:0] op, input logic [31:0] d, input int n,
                         input bit q, input bit rd, output logic [31:0] rx);
        logic [39:0] s;
        s = {op, d};
        rx = 32'h0000_0000;
        #37 spi_cs_b = 1'h0;
        for (int i = 0; i < 8 + n; i += (q ? 4 : 1)) begin
            if (rd && i >= 8)
                dq_in = ~dq_in; // released line toggles
            else
                dq_in = q ? s[39 - i -: 4] : {~dq_in[3:1], s[39 - i]};
            #200 spi_sck = 1'h1;
            if (i >= 8)
                rx = q ? {rx[27:0], dq_line} : {rx[30:0], dq_line[1]};
            #200 spi_sck = 1'h0;
        end
        #200 spi_cs_b = 1'h1;
        dq_in = ~dq_in;
        #400;
    endtask
endmodule // fsr_host_model

//--- verif/fsr_ctrl_chk.sv
// concurrent checks on the status register block ports
`timescale 1ns/1ps
module fsr_ctrl_chk #(
    parameter T_W_NS = 2000000
) (
    // clock and reset
    input wire       clk_sys,
    input wire       rst_b,
    // command and array side
    input wire       array_busy,
    input wire       erase_active,
    input wire       program_active,
    input wire       suspend_req,
    input wire       byte_programmed,
    // watched outputs
    input wire [3:0] dq_oe,
    input wire [7:0] status_one,
    input wire [7:0] status_two,
    input wire [7:0] status_three,
    input wire       write_busy_flag,
    input wire       write_enable_latch,
    input wire       hardware_protected_mode,
    input wire       hold_pin_active,
    input wire       reset_pin_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // register content relations and output enable codes
    chk_rsvd_zero: assert property (!status_two[0])
        else $error("reserved bit set");
    chk_busy_mirror: assert property (array_busy |-> write_busy_flag && status_one[0])
        else $error("busy flag missed");
    chk_hpm_cause: assert property (hardware_protected_mode |-> status_one[7] && !status_two[1])
        else $error("protect mode without cause");
    chk_pin_select: assert property (hold_pin_active == (!status_two[1] && !status_three[7])
        && reset_pin_active == (!status_two[1] && status_three[7])) else $error("pin select wrong");
    chk_lock_sticky: assert property ((status_two[5:3] & $past(status_two[5:3]))
        == $past(status_two[5:3])) else $error("lock bit cleared");
    chk_blank_stays: assert property (!$rose(status_three[2]))
        else $error("blank flag restored");
    chk_blank_clear: assert property (byte_programmed |-> ##[1:2] !status_three[2])
        else $error("blank flag kept");
    chk_erase_susp: assert property (suspend_req && erase_active |-> ##[1:2] status_two[7])
        else $error("erase suspend flag missed");
    chk_prog_susp: assert property (suspend_req && program_active |-> ##[1:2] status_two[2])
        else $error("program suspend flag missed");
    chk_wel_drop: assert property ($fell(write_busy_flag) |-> !write_enable_latch)
        else $error("latch kept after cycle");
    chk_oe_codes: assert property (dq_oe == 4'h0 || dq_oe == 4'h2 || dq_oe == 4'hf)
        else $error("odd output enable");
endmodule // fsr_ctrl_chk
bind fsr_ctrl fsr_ctrl_chk #(.T_W_NS(T_W_NS)) u_fsr_ctrl_chk (
    .clk_sys, .rst_b, .array_busy, .erase_active, .program_active, .suspend_req,
    .byte_programmed, .dq_oe, .status_one, .status_two, .status_three, .write_busy_flag,
    .write_enable_latch, .hardware_protected_mode, .hold_pin_active, .reset_pin_active
);

//--- verif/fsr_ctrl_bench.sv
// self-checking bench for the flash status register block
`timescale 1ns/1ps
module fsr_ctrl_bench;
    logic        clk_sys, rst_b, wp_b, qpi_mode, array_busy, erase_active, program_active;
    logic [4:0]  ev;
    wire         suspend_req, resume_req, wel_set, wel_clr, byte_programmed;
    wire         spi_sck, spi_cs_b, write_busy_flag, write_enable_latch;
    wire         hardware_protected_mode, hold_pin_active, reset_pin_active;
    wire  [2:0]  otp_sector_locked;
    wire  [1:0]  drive_strength, wrap_burst_len;
    wire  [3:0]  dq_in, dq_out, dq_oe;
    wire  [7:0]  status_one, status_two, status_three;
    logic [31:0] rx, rnd;
    logic [7:0]  e1, e2, e3;
    int          n_fail, checks_done, k;
    assign {suspend_req, resume_req, wel_set, wel_clr, byte_programmed} = ev;
    // short timed cycle: 500 clocks
    fsr_ctrl #(.T_W_NS(25000)) u_fsr_ctrl (
        .clk_sys, .rst_b, .spi_sck, .spi_cs_b, .dq_in, .dq_out, .dq_oe, .wp_b, .qpi_mode,
        .wel_set, .wel_clr, .array_busy, .erase_active, .program_active, .suspend_req,
        .resume_req, .byte_programmed, .status_one, .status_two, .status_three,
        .write_busy_flag, .write_enable_latch, .hardware_protected_mode,
        .otp_sector_locked, .hold_pin_active, .reset_pin_active, .drive_strength,
        .wrap_burst_len
    );
    fsr_host_model u_fsr_host_model (.spi_sck, .spi_cs_b, .dq_in, .dq_out, .dq_oe);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // second register after a write: locks only gain ones, flags untouched, bit 0 zero
    function automatic logic [7:0] nxt_s2(input logic [7:0] o, input logic [7:0] b);
        return {o[7], b[6], o[5:3] | b[5:3], o[2], b[1], 1'h0};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one-cycle event pulse
    task automatic pul(input logic [4:0] m);
        @(negedge clk_sys) ev = m;
        @(negedge clk_sys) ev = 5'h00;
    endtask
    // status write after setting the latch; ok tells whether it must be taken
    task automatic wr(input logic [31:0] v, input int n, input bit q, input bit ok);
        int c;
        pul(5'h04);
        @(negedge clk_sys) qpi_mode = q;
        u_fsr_host_model.frame(8'h01, v, n, q, 1'b0, rx);
        check("busy", write_busy_flag, ok);
        if (ok) begin
            e1 = {v[31:26], 2'h3};
            if (n > 8)
                e2 = nxt_s2(e2, v[23:16]);
            if (n == 32)
                e3 = {v[15:11], e3[2], 2'h0};
            check("s1 busy", status_one, e1);
            for (c = 0; c < 600 && write_busy_flag; c++)
                @(negedge clk_sys);
            check("tw", c > 450 && c < 600, 1);
            e1[1:0] = 2'h0;
        end
        else
            pul(5'h02);
        check("s1", status_one, e1);
        check("s2", status_two, e2);
        check("s3", status_three, e3);
        check("locks", otp_sector_locked, {e2[3], e2[4], e2[5]});
        check("pin", {hold_pin_active, reset_pin_active}, {~e2[1] & ~e3[7], ~e2[1] & e3[7]});
        check("fields", {drive_strength, wrap_burst_len}, e3[6:3]);
    endtask
    // read third register twice over in one frame
    task automatic rd3(input logic [7:0] op, input bit q);
        @(negedge clk_sys) qpi_mode = q;
        u_fsr_host_model.frame(op, 32'h0000_0000, 16, q, 1'b1, rx);
        check("rd3", rx[15:0], {e3, e3});
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // system clock
    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end
    // main sequence
    initial begin
        {rst_b, wp_b, qpi_mode, array_busy, erase_active, program_active} = 6'h10;
        {ev, n_fail, checks_done, e1, e2, e3} = {5'h00, 64'h0, 24'h00_0204};
        rnd = 32'h0000_8e51;
        repeat (4) @(negedge clk_sys);
        rst_b = 1'h1;
        repeat (3) @(negedge clk_sys);
        check("s1", status_one, e1);
        check("s2", status_two, e2);
        check("s3", status_three, e3);
        for (k = 0; k < 2; k++) begin
            @(negedge clk_sys) {erase_active, program_active} = k ? 2'h1 : 2'h2;
            pul(5'h10);
            check("suspend", status_two, k ? 8'h06 : 8'h82);
            pul(5'h08);
            check("resume", status_two, e2);
        end
        {erase_active, program_active, array_busy} = 3'h1;
        repeat (3) @(negedge clk_sys);
        array_busy = 1'h0;
        u_fsr_host_model.frame(8'h01, 32'hfc00_0000, 8, 1'b0, 1'b0, rx);
        check("no latch", write_busy_flag, 0);
        wr(32'hfc00_0000, 12, 0, 0);
        wr(32'hfc00_0000, 24, 0, 0);
        for (k = 0; k < 6; k++) begin
            repeat (11) rnd = lfsr(rnd);
            wr(rnd, 8 << (k % 3), k > 2, 1);
        end
        rd3(8'h95, 0);
        rd3(8'h15, 1);
        pul(5'h01);
        e3[2] = 1'h0;
        rd3(8'h15, 0);
        wr(32'hc000_0000, 16, 0, 1);
        @(negedge clk_sys) wp_b = 1'h0;
        repeat (3) @(negedge clk_sys);
        check("hpm", hardware_protected_mode, 1);
        wr(32'h0000_0000, 8, 0, 0);
        @(negedge clk_sys) wp_b = 1'h1;
        wr(32'h0000_0000, 8, 1, 1);
        // second reset with the latch and a suspend flag set
        pul(5'h04);
        @(negedge clk_sys) {erase_active, program_active} = 2'h2;
        pul(5'h10);
        check("pre rst", {write_enable_latch, status_two[7]}, 2'h3);
        @(negedge clk_sys) rst_b = 1'h0;
        {e1, e2, e3} = 24'h00_0204;
        repeat (4) @(negedge clk_sys);
        rst_b = 1'h1;
        repeat (3) @(negedge clk_sys);
        check("s1 rst", status_one, e1);
        check("s2 rst", status_two, e2);
        check("s3 rst", status_three, e3);
        results;
    end
    // watchdog: about five times the expected run
    initial begin
        #1_500_000;
        n_fail++;
        results;
    end
endmodule // fsr_ctrl_bench
